// [servo_alarm_supervisor.sv]
`timescale 1ns/1ps
// Function
// - Latch five separate protection alarms
// - Flash lamp while any alarm active
// - Alarm drops motor power and servo loop
// - Status reads still served during alarm
// - Alarm discards all motion, error frozen
// - Alarms clear only at power-up reset
// - Serial port always active after power-on
// - Non-serial source: serial motion rejected
// - Host initiates, device only replies
// - New serial target retargets at once
// - Readable status: alarm, busy, inpos, enable
// - Readable, writable configuration byte
// - Report 16-bit single, 32-bit multi-turn
// - Start constant, square, sine profiles
// - Point moves, 3-axis line and arc
// - 38400 8N1, reply bytes back to back
// - No acknowledge, act on request directly
module servo_alarm_supervisor #(
	parameter int FLASH_CYCLES = servo_alarm_pkg::FLASH_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// Fault detector pins: volt, temp, phase, power, current
	input wire logic [4:0] i_fault,
	// Serial pins
	input wire logic i_rxd,
	output logic o_txd,
	output logic [7:0] o_rx_byte,
	output logic o_rx_valid,
	// Decoded request from packet layer
	input wire logic i_req_valid,
	input wire logic [4:0] i_req_func,
	input wire logic [31:0] i_req_data,
	// Pulse and analog command sources
	input wire logic i_step_valid,
	input wire logic i_step_dir,
	input wire logic i_analog_valid,
	input wire logic [15:0] i_analog_delta,
	// Encoder position
	input wire logic [15:0] i_enc_single,
	input wire logic [31:0] i_enc_multi,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Drive outputs
	output logic o_lamp,
	output logic o_motor_pwr_en,
	output logic o_servo_loop_en,
	output logic [4:0] o_alarm,
	output logic [31:0] o_pos_err,
	output logic [31:0] o_target,
	output logic o_move_start,
	output logic [4:0] o_move_kind,
	output logic [31:0] o_move_data,
	output logic [2:0] o_move_axes,
	output logic o_irq
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [4:0] fault_s1; // First sync stage
		logic [4:0] fault_s2; // Second sync stage
		logic [4:0] alarm; // Latched alarms
		logic rx_s1;
		logic rx_s2;
		logic [7:0] cfg;
		logic [31:0] target;
		logic [31:0] pos_err;
		logic [2:0] irq_st;
		logic [2:0] irq_mask;
		logic [31:0] rdata;
		logic [31:0] lamp_cnt;
		logic lamp;
		servo_alarm_pkg::uart_st_t rx_st;
		logic [11:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_v;
		servo_alarm_pkg::uart_st_t tx_st;
		logic [11:0] tx_cnt;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		logic [31:0] tx_buf; // Pending reply bytes, low first
		logic [2:0] tx_left;
		logic txd;
		logic mv;
		logic [4:0] mv_kind;
		logic [31:0] mv_data;
		logic [2:0] mv_axes;
	} state_t;

	state_t s_reg;
	state_t s_next;

	// Helper views of the current state
	logic any_alarm;
	logic enabled;
	logic [2:0] src;
	logic busy;
	logic in_pos;
	logic [31:0] err_abs;
	logic [7:0] status_word;
	logic is_motion;
	logic [2:0] ev;
	logic [31:0] new_target;

	assign any_alarm = |s_reg.alarm;
	assign enabled = s_reg.cfg[servo_alarm_pkg::CFG_EN];
	assign src = s_reg.cfg[servo_alarm_pkg::CFG_MODE_LO +: 3];
	assign err_abs = s_reg.pos_err[31] ? 32'(-s_reg.pos_err) : s_reg.pos_err;
	assign in_pos = err_abs <= 32'(servo_alarm_pkg::ON_RANGE);
	assign busy = !in_pos && enabled && !any_alarm;
	// Status byte: alarm, busy, in-position, enable, alarm bits
	assign status_word = {any_alarm, busy, in_pos, enabled, 4'h0} | {3'h0, s_reg.alarm};

	// Motion class of the incoming function
	always_comb begin
		case (i_req_func)
			servo_alarm_pkg::FN_SET_ORIGIN, servo_alarm_pkg::FN_GO_ABS,
			servo_alarm_pkg::FN_LINE, servo_alarm_pkg::FN_GO_REL,
			servo_alarm_pkg::FN_ARC, servo_alarm_pkg::FN_CONST,
			servo_alarm_pkg::FN_SQUARE, servo_alarm_pkg::FN_SINE,
			servo_alarm_pkg::FN_SWEEP: begin
				is_motion = 1'b1;
			end
			default: begin
				is_motion = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		ev = 3'h0;
		new_target = s_reg.target;
		s_next.mv = 1'b0;
		s_next.rx_v = 1'b0;
		// Fault pins through two flops, then latched for good
		s_next.fault_s1 = i_fault;
		s_next.fault_s2 = s_reg.fault_s1;
		s_next.alarm = s_reg.alarm | s_reg.fault_s2;
		ev[servo_alarm_pkg::IRQ_ALARM] = |(s_reg.fault_s2 & ~s_reg.alarm);
		// Lamp toggles each half period while alarmed
		if (any_alarm) begin
			if (s_reg.lamp_cnt == 32'(FLASH_CYCLES - 1)) begin
				s_next.lamp_cnt = 32'h0;
				s_next.lamp = !s_reg.lamp;
			end else begin
				s_next.lamp_cnt = s_reg.lamp_cnt + 32'h1;
			end
		end
		// Pulse and analog sources, dropped while alarmed
		if (!any_alarm && enabled) begin
			if ((src == servo_alarm_pkg::SRC_PULSE_DIR || src == servo_alarm_pkg::SRC_CW_CCW)
				&& i_step_valid) begin
				s_next.pos_err = i_step_dir ? s_reg.pos_err - 32'h1 : s_reg.pos_err + 32'h1;
			end else if (src == servo_alarm_pkg::SRC_ANALOG && i_analog_valid) begin
				s_next.pos_err = s_reg.pos_err + {{16{i_analog_delta[15]}}, i_analog_delta};
			end
		end
		// Serial requests, acted on with no acknowledge
		if (i_req_valid) begin
			if (is_motion) begin
				if (any_alarm) begin
					// Discarded silently
				end else if (src != servo_alarm_pkg::SRC_SERIAL) begin
					ev[servo_alarm_pkg::IRQ_REJECT] = 1'b1;
				end else begin
					s_next.mv = 1'b1;
					s_next.mv_kind = i_req_func;
					s_next.mv_data = i_req_data;
					s_next.mv_axes = i_req_data[2:0];
					ev[servo_alarm_pkg::IRQ_MOVE] = 1'b1;
					case (i_req_func)
						servo_alarm_pkg::FN_SET_ORIGIN: begin
							new_target = 32'h0;
							s_next.pos_err = 32'h0;
						end
						servo_alarm_pkg::FN_GO_ABS, servo_alarm_pkg::FN_LINE,
						servo_alarm_pkg::FN_ARC: begin
							new_target = i_req_data;
							s_next.pos_err = i_req_data - i_enc_multi;
						end
						servo_alarm_pkg::FN_GO_REL: begin
							new_target = s_reg.target + i_req_data;
							s_next.pos_err = new_target - i_enc_multi;
						end
						default: begin
							new_target = s_reg.target;
						end
					endcase
					s_next.target = new_target;
				end
			end else if (i_req_func == servo_alarm_pkg::FN_SET_CFG) begin
				s_next.cfg = i_req_data[7:0];
			end else if (s_reg.tx_left == 3'h0 && s_reg.tx_st == servo_alarm_pkg::U_IDLE) begin
				// Reads are served in alarm too
				case (i_req_func)
					servo_alarm_pkg::FN_READ_STATUS: begin
						s_next.tx_buf = {24'h0, status_word};
						s_next.tx_left = 3'h1;
					end
					servo_alarm_pkg::FN_READ_CFG: begin
						s_next.tx_buf = {24'h0, s_reg.cfg};
						s_next.tx_left = 3'h1;
					end
					servo_alarm_pkg::FN_READ_POS: begin
						if (i_req_data[0]) begin
							s_next.tx_buf = i_enc_multi;
							s_next.tx_left = 3'h4;
						end else begin
							s_next.tx_buf = {16'h0, i_enc_single};
							s_next.tx_left = 3'h2;
						end
					end
					default: begin
						s_next.tx_left = 3'h0;
					end
				endcase
			end
		end
		// Receiver, always running
		s_next.rx_s1 = i_rxd;
		s_next.rx_s2 = s_reg.rx_s1;
		case (s_reg.rx_st)
			servo_alarm_pkg::U_IDLE: begin
				if (!s_reg.rx_s2) begin
					s_next.rx_st = servo_alarm_pkg::U_START;
					s_next.rx_cnt = servo_alarm_pkg::HALF_LAST;
				end
			end
			servo_alarm_pkg::U_START: begin
				if (s_reg.rx_cnt != 12'h0) begin
					s_next.rx_cnt = s_reg.rx_cnt - 12'h1;
				end else if (s_reg.rx_s2) begin
					s_next.rx_st = servo_alarm_pkg::U_IDLE; // Glitch
				end else begin
					s_next.rx_st = servo_alarm_pkg::U_DATA;
					s_next.rx_cnt = servo_alarm_pkg::BIT_LAST;
					s_next.rx_bit = 3'h0;
				end
			end
			servo_alarm_pkg::U_DATA: begin
				if (s_reg.rx_cnt != 12'h0) begin
					s_next.rx_cnt = s_reg.rx_cnt - 12'h1;
				end else begin
					s_next.rx_sh = {s_reg.rx_s2, s_reg.rx_sh[7:1]};
					s_next.rx_cnt = servo_alarm_pkg::BIT_LAST;
					s_next.rx_bit = s_reg.rx_bit + 3'h1;
					if (s_reg.rx_bit == 3'h7) begin
						s_next.rx_st = servo_alarm_pkg::U_STOP;
					end
				end
			end
			servo_alarm_pkg::U_STOP: begin
				if (s_reg.rx_cnt != 12'h0) begin
					s_next.rx_cnt = s_reg.rx_cnt - 12'h1;
				end else begin
					s_next.rx_st = servo_alarm_pkg::U_IDLE;
					s_next.rx_v = s_reg.rx_s2; // Framing error drops byte
				end
			end
			default: begin
				s_next.rx_st = servo_alarm_pkg::U_IDLE;
			end
		endcase
		// Transmitter, reply bytes back to back
		case (s_reg.tx_st)
			servo_alarm_pkg::U_IDLE: begin
				s_next.txd = 1'b1;
				if (s_reg.tx_left != 3'h0) begin
					s_next.tx_st = servo_alarm_pkg::U_START;
					s_next.tx_cnt = servo_alarm_pkg::BIT_LAST;
					s_next.tx_sh = s_reg.tx_buf[7:0];
					s_next.tx_buf = {8'h0, s_reg.tx_buf[31:8]};
					s_next.tx_left = s_reg.tx_left - 3'h1;
					s_next.txd = 1'b0;
				end
			end
			servo_alarm_pkg::U_START: begin
				if (s_reg.tx_cnt != 12'h0) begin
					s_next.tx_cnt = s_reg.tx_cnt - 12'h1;
				end else begin
					s_next.tx_st = servo_alarm_pkg::U_DATA;
					s_next.tx_cnt = servo_alarm_pkg::BIT_LAST;
					s_next.tx_bit = 3'h0;
					s_next.txd = s_reg.tx_sh[0];
				end
			end
			servo_alarm_pkg::U_DATA: begin
				if (s_reg.tx_cnt != 12'h0) begin
					s_next.tx_cnt = s_reg.tx_cnt - 12'h1;
				end else begin
					s_next.tx_cnt = servo_alarm_pkg::BIT_LAST;
					s_next.tx_bit = s_reg.tx_bit + 3'h1;
					s_next.tx_sh = {1'b0, s_reg.tx_sh[7:1]};
					if (s_reg.tx_bit == 3'h7) begin
						s_next.tx_st = servo_alarm_pkg::U_STOP;
						s_next.txd = 1'b1;
					end else begin
						s_next.txd = s_reg.tx_sh[1];
					end
				end
			end
			servo_alarm_pkg::U_STOP: begin
				if (s_reg.tx_cnt != 12'h0) begin
					s_next.tx_cnt = s_reg.tx_cnt - 12'h1;
				end else if (s_reg.tx_left != 3'h0) begin
					s_next.tx_st = servo_alarm_pkg::U_START;
					s_next.tx_cnt = servo_alarm_pkg::BIT_LAST;
					s_next.tx_sh = s_reg.tx_buf[7:0];
					s_next.tx_buf = {8'h0, s_reg.tx_buf[31:8]};
					s_next.tx_left = s_reg.tx_left - 3'h1;
					s_next.txd = 1'b0;
				end else begin
					s_next.tx_st = servo_alarm_pkg::U_IDLE;
				end
			end
			default: begin
				s_next.tx_st = servo_alarm_pkg::U_IDLE;
			end
		endcase
		// Register writes; bus wins over serial config
		if (i_wr) begin
			case (i_addr)
				servo_alarm_pkg::OFF_CONFIG: begin
					s_next.cfg = i_wdata[7:0];
				end
				servo_alarm_pkg::OFF_IRQ_ST: begin
					s_next.irq_st = s_reg.irq_st & ~i_wdata[2:0];
				end
				servo_alarm_pkg::OFF_IRQ_MASK: begin
					s_next.irq_mask = i_wdata[2:0];
				end
				default: begin
					s_next.irq_mask = s_reg.irq_mask;
				end
			endcase
		end
		// New events win over a same-cycle clear
		s_next.irq_st = s_next.irq_st | ev;
		// Read data one cycle after the strobe
		s_next.rdata = 32'h0;
		if (i_rd) begin
			case (i_addr)
				servo_alarm_pkg::OFF_STATUS: s_next.rdata = {24'h0, status_word};
				servo_alarm_pkg::OFF_CONFIG: s_next.rdata = {24'h0, s_reg.cfg};
				servo_alarm_pkg::OFF_IRQ_ST: s_next.rdata = {29'h0, s_reg.irq_st};
				servo_alarm_pkg::OFF_IRQ_MASK: s_next.rdata = {29'h0, s_reg.irq_mask};
				servo_alarm_pkg::OFF_POS_ERR: s_next.rdata = s_reg.pos_err;
				default: s_next.rdata = 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s_reg <= '0;
			s_reg.rx_s1 <= 1'b1;
			s_reg.rx_s2 <= 1'b1;
			s_reg.txd <= 1'b1;
			s_reg.cfg <= servo_alarm_pkg::CFG_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs
	assign o_txd = s_reg.txd;
	assign o_rx_byte = s_reg.rx_sh;
	assign o_rx_valid = s_reg.rx_v;
	assign o_rdata = s_reg.rdata;
	assign o_lamp = s_reg.lamp;
	assign o_motor_pwr_en = enabled && !any_alarm;
	assign o_servo_loop_en = enabled && !any_alarm;
	assign o_alarm = s_reg.alarm;
	assign o_pos_err = s_reg.pos_err;
	assign o_target = s_reg.target;
	assign o_move_start = s_reg.mv;
	assign o_move_kind = s_reg.mv_kind;
	assign o_move_data = s_reg.mv_data;
	assign o_move_axes = s_reg.mv_axes;
	assign o_irq = |(s_reg.irq_st & s_reg.irq_mask);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_alarm_latch;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		s_reg.fault_s2[0] |=> s_reg.alarm[0] [*8];
	endproperty
	a_alarm_latch: assert property (p_alarm_latch) else $error("alarm not latched");

	property p_lamp_dark;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		!any_alarm |-> !o_lamp;
	endproperty
	a_lamp_dark: assert property (p_lamp_dark) else $error("lamp lit without alarm");

	property p_power_off;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		any_alarm |-> !o_motor_pwr_en && !o_servo_loop_en;
	endproperty
	a_power_off: assert property (p_power_off) else $error("motor powered in alarm");

	property p_err_frozen;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		any_alarm |=> $stable(s_reg.pos_err) && !o_move_start;
	endproperty
	a_err_frozen: assert property (p_err_frozen) else $error("command taken in alarm");

	property p_alarm_sticky;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		s_reg.alarm != 5'h0 |=> (s_reg.alarm & $past(s_reg.alarm)) == $past(s_reg.alarm);
	endproperty
	a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm cleared");

	property p_reject;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_req_valid && is_motion && !any_alarm && src != servo_alarm_pkg::SRC_SERIAL
		|=> !o_move_start && s_reg.irq_st[servo_alarm_pkg::IRQ_REJECT];
	endproperty
	a_reject: assert property (p_reject) else $error("motion not rejected");

	property p_retarget;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_req_valid && i_req_func == servo_alarm_pkg::FN_GO_ABS && !any_alarm
		&& src == servo_alarm_pkg::SRC_SERIAL |=> o_target == $past(i_req_data) && o_move_start;
	endproperty
	a_retarget: assert property (p_retarget) else $error("target not updated");

	property p_tx_quiet;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		s_reg.tx_st == servo_alarm_pkg::U_IDLE && s_reg.tx_left == 3'h0 && !i_req_valid
		|=> s_reg.tx_st == servo_alarm_pkg::U_IDLE && o_txd;
	endproperty
	a_tx_quiet: assert property (p_tx_quiet) else $error("unsolicited transmit");

	property p_read_data;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_rd && i_addr == servo_alarm_pkg::OFF_CONFIG |=> o_rdata == {24'h0, $past(s_reg.cfg)};
	endproperty
	a_read_data: assert property (p_read_data) else $error("config read wrong");

	c_alarm: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) $rose(any_alarm));
	c_move: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) o_move_start);
	c_reply: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		s_reg.tx_st == servo_alarm_pkg::U_STOP ##1 s_reg.tx_st == servo_alarm_pkg::U_START);
	c_rx: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) o_rx_valid);
endmodule

// [servo_alarm_pkg.sv]
package servo_alarm_pkg;
	// ------------------------------------------------------------
	// Clock, line rate and lamp timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 125000000;
	localparam int BAUD = 38400;
	localparam int BIT_CYC = CLK_HZ / BAUD; // 3255 cycles a bit
	localparam logic [11:0] BIT_LAST = 12'(BIT_CYC - 1);
	localparam logic [11:0] HALF_LAST = 12'(BIT_CYC / 2 - 1);
	localparam int FLASH_MS = 250; // Lamp half period
	localparam int FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
	localparam logic [4:0] ON_RANGE = 5'h10; // In-position window
	// ------------------------------------------------------------
	// Register offsets and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_CONFIG = 8'h04;
	localparam logic [7:0] OFF_IRQ_ST = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
	localparam logic [7:0] OFF_POS_ERR = 8'h10;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// Config fields
	localparam int CFG_ABS = 2;
	localparam int CFG_MODE_LO = 3;
	localparam int CFG_EN = 6;
	// Irq status bits
	localparam int IRQ_ALARM = 0;
	localparam int IRQ_REJECT = 1;
	localparam int IRQ_MOVE = 2;
	// Command sources
	localparam logic [2:0] SRC_SERIAL = 3'h0;
	localparam logic [2:0] SRC_PULSE_DIR = 3'h1;
	localparam logic [2:0] SRC_CW_CCW = 3'h2;
	localparam logic [2:0] SRC_ANALOG = 3'h4;
	// ------------------------------------------------------------
	// Serial function codes
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		FN_SET_ORIGIN = 5'h00, FN_GO_ABS = 5'h01, FN_LINE = 5'h02,
		FN_GO_REL = 5'h03, FN_ARC = 5'h04, FN_SET_CFG = 5'h07,
		FN_READ_CFG = 5'h08, FN_READ_STATUS = 5'h09, FN_CONST = 5'h0a,
		FN_SQUARE = 5'h0b, FN_SINE = 5'h0c, FN_SWEEP = 5'h0d,
		FN_READ_POS = 5'h0e
	} func_t;
	// UART states, Gray along the frame
	typedef enum logic [1:0] {
		U_IDLE = 2'h0, U_START = 2'h1, U_DATA = 2'h3, U_STOP = 2'h2
	} uart_st_t;
endpackage

// [host_serial_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side receiver of the reply line
// ------------------------------------------------------------
module host_serial_model (
	input wire logic i_ref_clk,
	input wire logic i_txd,
	output logic [8:0] o_byte,
	output logic o_valid
);
	int k; // Bit index within a frame
	initial begin
		o_byte = 9'h000;
		o_valid = 1'b0;
	end
	// Host only listens; any start bit it sees is a reply to its request
	always begin
		@(negedge i_txd);
		// Sample each bit in its middle, 8N1, LSB first
		repeat (servo_alarm_pkg::BIT_CYC / 2) @(posedge i_ref_clk);
		for (k = 0; k < 8; k++) begin
			repeat (servo_alarm_pkg::BIT_CYC) @(posedge i_ref_clk);
			o_byte[k] <= i_txd;
		end
		// Stop bit lands in bit 8 of the report
		repeat (servo_alarm_pkg::BIT_CYC) @(posedge i_ref_clk);
		o_byte[8] <= i_txd;
		o_valid <= 1'b1;
		@(posedge i_ref_clk);
		o_valid <= 1'b0;
	end
endmodule

// [servo_alarm_supervisor_bench.sv]
`timescale 1ns/1ps
module servo_alarm_supervisor_bench;
	// ------------------------------------------------------------
	// Design inputs and outputs
	// ------------------------------------------------------------
	logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_rxd = 1'b1;
	logic [4:0] i_fault = 5'h00, i_req_func = 5'h00;
	logic i_req_valid = 1'b0, i_step_valid = 1'b0, i_step_dir = 1'b0, i_analog_valid = 1'b0;
	logic [31:0] i_req_data = 32'h0, i_enc_multi = 32'h0, i_wdata = 32'h0;
	logic [15:0] i_analog_delta = 16'h0, i_enc_single = 16'h0;
	logic [7:0] i_addr = 8'h00;
	logic i_wr = 1'b0, i_rd = 1'b0;
	logic o_txd, o_lamp, o_motor_pwr_en, o_servo_loop_en, o_move_start, o_irq, o_rx_valid;
	logic [7:0] o_rx_byte; // Byte taken in by the receiver
	logic [31:0] o_rdata, o_pos_err, o_target, o_move_data;
	logic [4:0] o_alarm, o_move_kind;
	logic [2:0] o_move_axes;
	logic [8:0] host_byte; // Stop bit and data byte seen by host
	logic host_valid;
	// Expected-result notes, oldest first
	logic [31:0] rd_exp[$], rd_msk[$];
	logic [36:0] mv_exp[$];
	logic [8:0] tx_exp[$];
	logic [7:0] rx_exp[$];
	logic rd_seen = 1'b0; // Read taken last edge
	int fails = 0, comparisons = 0, cyc = 0, b, hi, seed;
	logic [31:0] d, d2;
	always #4 i_ref_clk = ~i_ref_clk;
	servo_alarm_supervisor #(.FLASH_CYCLES(8)) servo_alarm_supervisor_inst (.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst), .i_fault(i_fault), .i_rxd(i_rxd), .o_txd(o_txd), .o_rx_byte(o_rx_byte),
		.o_rx_valid(o_rx_valid), .i_req_valid(i_req_valid), .i_req_func(i_req_func), .i_req_data(i_req_data),
		.i_step_valid(i_step_valid), .i_step_dir(i_step_dir), .i_analog_valid(i_analog_valid),
		.i_analog_delta(i_analog_delta), .i_enc_single(i_enc_single), .i_enc_multi(i_enc_multi),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_lamp(o_lamp), .o_motor_pwr_en(o_motor_pwr_en), .o_servo_loop_en(o_servo_loop_en),
		.o_alarm(o_alarm), .o_pos_err(o_pos_err), .o_target(o_target), .o_move_start(o_move_start),
		.o_move_kind(o_move_kind), .o_move_data(o_move_data), .o_move_axes(o_move_axes), .o_irq(o_irq));
	host_serial_model host_serial_model_inst (.i_ref_clk(i_ref_clk), .i_txd(o_txd), .o_byte(host_byte),
		.o_valid(host_valid));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	// Masked comparison, counted
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s, input logic [31:0] m);
		comparisons++;
		if ((s & m) !== (e & m)) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	// Reset held for 3 cycles
	task automatic do_reset();
		i_sys_rst <= 1'b1;
		tick(3);
		i_sys_rst <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	// Read with an expected value and a mask noted for the watcher
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		rd_exp.push_back(e);
		rd_msk.push_back(m);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
	endtask
	task automatic req(input logic [4:0] f, input logic [31:0] v);
		@(posedge i_ref_clk);
		i_req_valid <= 1'b1;
		i_req_func <= f;
		i_req_data <= v;
		@(posedge i_ref_clk);
		i_req_valid <= 1'b0;
	endtask
	// ------------------------------------------------------------
	// Output watchers
	// ------------------------------------------------------------
	always @(posedge i_ref_clk) begin
		rd_seen <= i_rd;
		cyc++;
		// Ceiling well above the two reply bytes
		if (cyc == 90000) begin
			fails++;
			conclude();
		end
	end
	always @(negedge i_ref_clk) begin
		// Read data stands only in the cycle after the strobe
		if (rd_seen) begin
			check("rdata", rd_exp.pop_front(), o_rdata, rd_msk.pop_front());
		end
		// Every move pulse must have been asked for
		if (o_move_start === 1'b1) begin
			if (mv_exp.size() == 0) begin
				check("unexpected move", 32'h0, 32'h1, 32'h1);
			end else begin
				check("move kind", 32'(mv_exp[0][36:32]), 32'(o_move_kind), 32'h1f);
				check("move axes", 32'(mv_exp[0][2:0]), 32'(o_move_axes), 32'h7);
				check("move data", mv_exp.pop_front()[31:0], o_move_data, 32'hffffffff);
			end
		end
		// Received byte against the frame that was sent
		if (o_rx_valid === 1'b1) begin
			check("rx byte", 32'(rx_exp.pop_front()), 32'(o_rx_byte), 32'hff);
		end
		// Reply bytes only as answers, with a good stop bit
		if (host_valid === 1'b1) begin
			if (tx_exp.size() == 0) begin
				check("unsolicited byte", 32'h0, 32'h1, 32'h1);
			end else begin
				check("reply byte", 32'(tx_exp.pop_front()), 32'(host_byte), 32'h1ff);
			end
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = $urandom(54);
		do_reset();
		// Power-up state: disabled, no lamp, config cleared
		@(negedge i_ref_clk);
		check("motor after reset", 32'h0, 32'(o_motor_pwr_en), 32'h1);
		check("lamp after reset", 32'h0, 32'(o_lamp), 32'h1);
		rd(servo_alarm_pkg::OFF_CONFIG, 32'(servo_alarm_pkg::CFG_RESET), 32'hffffffff);
		rd(servo_alarm_pkg::OFF_STATUS, 32'h20, 32'hffffffff);
		wr(8'h20, 32'hffffffff);
		rd(8'h20, 32'h0, 32'hffffffff);
		wr(servo_alarm_pkg::OFF_CONFIG, 32'h45);
		rd(servo_alarm_pkg::OFF_CONFIG, 32'h45, 32'hffffffff);
		$display("test reset and config done");
		// Every motion and profile code starts a move
		for (b = 0; b < 9; b++) begin
			d = $urandom();
			i_req_func <= 5'h0;
			case (b)
				0: d2 = 32'(servo_alarm_pkg::FN_GO_ABS);
				1: d2 = 32'(servo_alarm_pkg::FN_LINE);
				2: d2 = 32'(servo_alarm_pkg::FN_GO_REL);
				3: d2 = 32'(servo_alarm_pkg::FN_ARC);
				4: d2 = 32'(servo_alarm_pkg::FN_CONST);
				5: d2 = 32'(servo_alarm_pkg::FN_SQUARE);
				6: d2 = 32'(servo_alarm_pkg::FN_SINE);
				7: d2 = 32'(servo_alarm_pkg::FN_SWEEP);
				default: d2 = 32'(servo_alarm_pkg::FN_SET_ORIGIN);
			endcase
			mv_exp.push_back({d2[4:0], d});
			req(d2[4:0], d);
			tick(2);
		end
		// Two targets on consecutive edges, second wins at once
		d = $urandom();
		d2 = $urandom();
		mv_exp.push_back({servo_alarm_pkg::FN_GO_ABS, d});
		mv_exp.push_back({servo_alarm_pkg::FN_GO_ABS, d2});
		@(posedge i_ref_clk);
		i_req_valid <= 1'b1;
		i_req_func <= servo_alarm_pkg::FN_GO_ABS;
		i_req_data <= d;
		@(posedge i_ref_clk);
		i_req_data <= d2;
		@(posedge i_ref_clk);
		i_req_valid <= 1'b0;
		@(negedge i_ref_clk);
		check("retarget", d2, o_target, 32'hffffffff);
		$display("test motion done");
		// Pulse source: serial motion refused, config still reachable
		wr(servo_alarm_pkg::OFF_CONFIG, 32'h48);
		wr(servo_alarm_pkg::OFF_IRQ_MASK, 32'h2);
		req(servo_alarm_pkg::FN_GO_ABS, 32'h1234);
		tick(2);
		@(negedge i_ref_clk);
		check("irq refused", 32'h1, 32'(o_irq), 32'h1);
		check("target kept", d2, o_target, 32'hffffffff);
		rd(servo_alarm_pkg::OFF_IRQ_ST, 32'h2, 32'h2);
		wr(servo_alarm_pkg::OFF_IRQ_ST, 32'h2);
		@(negedge i_ref_clk);
		check("irq cleared", 32'h0, 32'(o_irq), 32'h1);
		req(servo_alarm_pkg::FN_SET_CFG, 32'h40);
		rd(servo_alarm_pkg::OFF_CONFIG, 32'h40, 32'hff);
		$display("test command source done");
		// Each alarm alone, after its own power-up
		for (b = 0; b < 5; b++) begin
			@(posedge i_ref_clk);
			do_reset();
			wr(servo_alarm_pkg::OFF_CONFIG, 32'h40);
			wr(servo_alarm_pkg::OFF_IRQ_MASK, 32'h1);
			d = $urandom();
			mv_exp.push_back({servo_alarm_pkg::FN_GO_ABS, d});
			req(servo_alarm_pkg::FN_GO_ABS, d);
			tick(2);
			@(negedge i_ref_clk);
			check("motor on", 32'h3, {30'h0, o_motor_pwr_en, o_servo_loop_en}, 32'h3);
			check("pos err", d, o_pos_err, 32'hffffffff);
			// Short fault, then gone again: alarm must stay
			@(posedge i_ref_clk);
			i_fault <= 5'(1 << b);
			tick(4);
			i_fault <= 5'h00;
			tick(3);
			@(negedge i_ref_clk);
			check("alarm latch", 32'(1 << b), 32'(o_alarm), 32'h1f);
			check("motor off", 32'h0, {30'h0, o_motor_pwr_en, o_servo_loop_en}, 32'h3);
			check("irq alarm", 32'h1, 32'(o_irq), 32'h1);
			rd(servo_alarm_pkg::OFF_STATUS, 32'(32'h90 | (1 << b)), 32'hffffffdf);
			// Pulse, analog and serial commands during alarm change nothing
			wr(servo_alarm_pkg::OFF_CONFIG, b[0] ? 32'h48 : 32'h60);
			i_step_valid <= 1'b1;
			i_analog_valid <= 1'b1;
			i_analog_delta <= 16'h0100;
			tick(3);
			i_step_valid <= 1'b0;
			i_analog_valid <= 1'b0;
			wr(servo_alarm_pkg::OFF_CONFIG, 32'h40);
			req(servo_alarm_pkg::FN_GO_REL, 32'h55);
			tick(2);
			@(negedge i_ref_clk);
			check("err frozen", d, o_pos_err, 32'hffffffff);
			check("target frozen", d, o_target, 32'hffffffff);
		end
		// Lamp flashes while the alarm stands
		hi = 0;
		repeat (48) begin
			@(negedge i_ref_clk);
			hi += int'(o_lamp === 1'b1);
		end
		check("lamp flash", 32'h1, 32'(hi >= 16 && hi <= 32), 32'h1);
		$display("test alarms done");
		// Position readout over the serial line during alarm
		@(posedge i_ref_clk);
		i_enc_single <= 16'($urandom());
		tick(2);
		tx_exp.push_back({1'b1, i_enc_single[7:0]});
		tx_exp.push_back({1'b1, i_enc_single[15:8]});
		req(servo_alarm_pkg::FN_READ_POS, 32'h0);
		// One random frame into the receiver while the reply goes out
		d = $urandom();
		d2 = {22'h0, 1'b1, d[7:0], 1'b0};
		rx_exp.push_back(d[7:0]);
		for (b = 0; b < 10; b++) begin
			i_rxd <= d2[b];
			tick(servo_alarm_pkg::BIT_CYC);
		end
		tick(10 * servo_alarm_pkg::BIT_CYC + 100);
		check("replies left", 32'h0, 32'(tx_exp.size()), 32'hffffffff);
		check("rx left", 32'h0, 32'(rx_exp.size()), 32'hffffffff);
		check("moves left", 32'h0, 32'(mv_exp.size()), 32'hffffffff);
		$display("test serial readout done");
		conclude();
	end
endmodule
